/* File: rtl/mixer_pkg.sv */
/*
  Shared constants and types for the product-sum accumulator and its register slave.
  Assumes a single 100 MHz clock domain and an AXI4-Lite master holding 32-bit data.
*/
// Overview of operation
// - With rounding on, the 24-bit product sum is rounded toward a 16-bit result.
// - Rounding applies only on the first cycle of each accumulation sequence.
// - Rounding adds one at weight two to the seventh, only when accumulate is low.
// - Feedthrough high shortens the cascade path to its minimum latency.
// - Feedthrough low, zero delays: output five steps later is cascade plus both products.
// - Cascade enable low latches the cascade word at accumulator bits 23 to 8.
// - Cascade enable high makes the cascade input ignored.
// - Accumulate low discards the prior accumulated sum.
// - Accumulate high adds the new product sum to the total, without rounding.
// - Word swap high presents the high output word.
// - Word swap low toggles low and high words on alternate steps.
// - Word swap low holds new results out of the output registers.
// - Low word is accumulator bits 15 to 0, high word bits 23 to 8.
// - Output enable low drives the output register contents, without waiting for a clock.
// - Output enable high releases every sum output line.
// - Data, cascade and sum values are two's complement.
// - Product negates act at entry, not delayed by the delay selects.
// - A port enable low shifts its delay pipeline; high holds it and loses input.
package mixer_pkg;

  // ==========================================================================
  // Widths
  localparam int DATA_W  = 12;
  localparam int CAS_W   = 16;
  localparam int SUM_W   = 24;
  localparam int WORD_W  = 16;
  localparam int DEPTH   = 16;
  localparam int SEL_W   = 4;
  localparam int CAS_LAG = 2;

  // ==========================================================================
  // Register offsets, byte addresses
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] DELAY_OFF  = 8'h04;
  localparam logic [7:0] ACCUM_OFF  = 8'h08;
  localparam logic [7:0] OUTPUT_OFF = 8'h0C;

  // ==========================================================================
  // Control register fields and reset value
  localparam int CTRL_ROUND = 0;
  localparam int CTRL_FEED  = 1;
  localparam int CTRL_SWAPN = 2;
  localparam int CTRL_OEN   = 3;
  localparam logic [3:0] CTRL_RESET  = 4'hC;
  localparam logic [15:0] DELAY_RESET = 16'h0000;
  localparam logic [SUM_W-1:0] ROUND_BIT = 24'h000080;

  // ==========================================================================
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One input sample with its per-sample controls.
  typedef struct packed {
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic [DATA_W-1:0] c;
    logic [DATA_W-1:0] d;
    logic [3:0]        port_input_enable_n;
    logic [CAS_W-1:0]  cascade_input;
    logic              cascade_input_enable_n;
    logic              accumulate_control;
    logic              product_one_negate;
    logic              product_two_negate;
  } sample_s;

endpackage : mixer_pkg

/* File: rtl/delay_pipe.sv */
/*
  Input delay pipeline with a selectable tap.
  Assumes the caller qualifies shift with its own flow control.
*/
`timescale 1ns/1ps
module delay_pipe
  import mixer_pkg::*;
#(
  parameter int W = DATA_W,
  parameter int N = DEPTH
) (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // Data and control
  input  wire logic                 shift,
  input  wire logic [W-1:0]         din,
  input  wire logic [$clog2(N)-1:0] sel,
  output logic      [W-1:0]         dout
);

  logic [W-1:0] stage [N];

  // =========================================================================
  // Shift chain; the whole chain holds when shift is low.
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_stage
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          stage[i] <= '0;
        end else if (shift) begin
          stage[i] <= (i == 0) ? din : stage[(i == 0) ? 0 : i - 1];
        end
      end
    end
  endgenerate

  // Tap zero is one stage of delay, the last tap is sixteen.
  assign dout = stage[sel];

endmodule : delay_pipe

/* File: rtl/word_buffer.sv */
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes a single clock; storage is flip-flops addressed by an index.
*/
`timescale 1ns/1ps
module word_buffer #(
  parameter int W = 16,
  parameter int N = 2
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int AW = $clog2(N);
  logic [W-1:0] mem [N];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  // =========================================================================
  // Honest full and empty from the occupancy count.
  assign in_ready  = (count != N[AW:0]);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write.
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(N - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(N - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule : word_buffer

/* File: rtl/product_sum_accumulate_output.sv */
/*
  Product-sum accumulator with swappable double output register.
  Holds the four input delay pipelines, two signed multipliers, rounding, cascade
  path, 24-bit accumulator, output word registers, a two-entry output buffer and an
  AXI4-Lite register slave.
  Assumes samples arrive from logic on aclk over a valid/ready stream, and that the
  consumer of the output word stream may stall; the whole datapath then holds.
*/
`timescale 1ns/1ps
module product_sum_accumulate_output
  import mixer_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Sample stream in
  input  wire logic              sample_valid,
  output logic                   sample_ready,
  input  wire sample_s           sample,
  // Output word stream
  output logic                   word_valid,
  input  wire logic              word_ready,
  output logic [WORD_W-1:0]      word_data,
  // Three-state sum bus
  output logic [WORD_W-1:0]      sum_output,
  output logic                   sum_output_oe_n,
  // AXI4-Lite write address
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [7:0]        s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // AXI4-Lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [7:0]        s_axi_araddr,
  // AXI4-Lite read data
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp
);

  // =========================================================================
  // Declarations
  logic [3:0]              ctrl;
  logic [15:0]             delay_sel;
  logic                    round_enable;
  logic                    cascade_feedthrough;
  logic                    word_swap_n;
  logic                    output_enable_n;
  logic                    step;
  logic                    buf_ready;

  logic [DATA_W-1:0]       tap [4];
  logic [DATA_W-1:0]       port_din [4];
  logic                    product_one_negate_s1;
  logic                    product_two_negate_s1;
  logic                    acc_s1;
  logic                    acc_s2;
  logic                    acc_s3;
  logic signed [SUM_W-1:0] prod_one;
  logic signed [SUM_W-1:0] prod_two;
  logic signed [SUM_W-1:0] next_prod_one;
  logic signed [SUM_W-1:0] next_prod_two;
  logic [SUM_W-1:0]        prod_sum;
  logic [SUM_W-1:0]        accum;
  logic [SUM_W-1:0]        cas_entry;
  logic [SUM_W-1:0]        cas_lag [CAS_LAG];
  logic [SUM_W-1:0]        cas_term;
  logic [WORD_W-1:0]       low_output_word;
  logic [WORD_W-1:0]       high_output_word;
  logic                    show_low;
  logic [WORD_W-1:0]       next_word;

  logic                    aw_held;
  logic                    w_held;
  logic [7:0]              aw_addr;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;

  // =========================================================================
  // Control fields.
  assign round_enable        = ctrl[CTRL_ROUND];
  assign cascade_feedthrough = ctrl[CTRL_FEED];
  assign word_swap_n         = ctrl[CTRL_SWAPN];
  assign output_enable_n     = ctrl[CTRL_OEN];

  // =========================================================================
  // Flow control. One step moves every stage at once, so a stalled consumer
  // freezes the pipeline rather than dropping a word mid-flight.
  assign sample_ready = buf_ready;
  assign step         = sample_valid && buf_ready;

  // =========================================================================
  // Input delay pipelines, one per multiplier port.
  assign port_din[0] = sample.a;
  assign port_din[1] = sample.b;
  assign port_din[2] = sample.c;
  assign port_din[3] = sample.d;

  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_port
      delay_pipe #(
        .W (DATA_W),
        .N (DEPTH)
      ) u_delay (
        .aclk    (aclk),
        .aresetn (aresetn),
        .shift   (step && !sample.port_input_enable_n[p]),
        .din     (port_din[p]),
        .sel     (delay_sel[p*SEL_W +: SEL_W]),
        .dout    (tap[p])
      );
    end
  endgenerate

  // =========================================================================
  // Per-sample controls get one register of their own, level with the first
  // pipeline stage; the delay selects do not stretch them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      product_one_negate_s1 <= 1'b0;
      product_two_negate_s1 <= 1'b0;
      acc_s1  <= 1'b0;
    end else if (step) begin
      product_one_negate_s1 <= sample.product_one_negate;
      product_two_negate_s1 <= sample.product_two_negate;
      acc_s1  <= sample.accumulate_control;
    end
  end

  // =========================================================================
  // Signed multipliers with optional negation of each product.
  always_comb begin
    next_prod_one = SUM_W'(signed'(tap[0]) * signed'(tap[1]));
    next_prod_two = SUM_W'(signed'(tap[2]) * signed'(tap[3]));
    if (product_one_negate_s1) begin
      next_prod_one = -next_prod_one;
    end
    if (product_two_negate_s1) begin
      next_prod_two = -next_prod_two;
    end
  end

  // Product stage.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prod_one <= '0;
      prod_two <= '0;
      acc_s2   <= 1'b0;
    end else if (step) begin
      prod_one <= next_prod_one;
      prod_two <= next_prod_two;
      acc_s2   <= acc_s1;
    end
  end

  // =========================================================================
  // Sum of products. The half-LSB at bit 7 is added only when a new sequence
  // starts, so a long accumulation carries a single rounding error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prod_sum <= '0;
      acc_s3   <= 1'b0;
    end else if (step) begin
      if (round_enable && !acc_s2) begin
        prod_sum <= prod_one + prod_two + ROUND_BIT;
      end else begin
        prod_sum <= prod_one + prod_two;
      end
      acc_s3 <= acc_s2;
    end
  end

  // =========================================================================
  // Cascade entry register. The word sits at bits 23 to 8; a disabled cascade
  // contributes nothing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cas_entry <= '0;
    end else if (step) begin
      if (!sample.cascade_input_enable_n) begin
        cas_entry <= {sample.cascade_input, 8'h00};
      end else begin
        cas_entry <= '0;
      end
    end
  end

  // Cascade lag line so that, without feedthrough, the cascade word meets
  // the products of the same sample at the accumulator.
  genvar k;
  generate
    for (k = 0; k < CAS_LAG; k++) begin : g_cas
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cas_lag[k] <= '0;
        end else if (step) begin
          cas_lag[k] <= (k == 0) ? cas_entry : cas_lag[(k == 0) ? 0 : k - 1];
        end
      end
    end
  endgenerate

  // Feedthrough takes the cascade straight from its entry register, which is
  // what lets a chain of devices pass partial sums with little lag.
  assign cas_term = cascade_feedthrough ? cas_entry : cas_lag[CAS_LAG-1];

  // =========================================================================
  // Accumulator.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      accum <= '0;
    end else if (step) begin
      if (acc_s3) begin
        accum <= accum + prod_sum + cas_term;
      end else begin
        accum <= prod_sum + cas_term;
      end
    end
  end

  // =========================================================================
  // Double output register. Loading stops while the swap control is low, so
  // software can read both halves of one frozen result.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_output_word  <= '0;
      high_output_word <= '0;
    end else if (step && word_swap_n) begin
      low_output_word  <= accum[15:0];
      high_output_word <= accum[23:8];
    end
  end

  // Toggle state: alternates on each step while swap is low.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      show_low <= 1'b0;
    end else if (step) begin
      show_low <= word_swap_n ? 1'b0 : !show_low;
    end
  end

  // Word chosen for the bus on this step.
  always_comb begin
    if (word_swap_n) begin
      next_word = high_output_word;
    end else begin
      next_word = show_low ? low_output_word : high_output_word;
    end
  end

  // Sum bus register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sum_output <= '0;
    end else if (step) begin
      sum_output <= next_word;
    end
  end

  // The enable is not clocked; the pad logic outside uses it to drive or float.
  assign sum_output_oe_n = output_enable_n;

  // =========================================================================
  // Output buffer. Every step pushes exactly the word that the bus register
  // takes, and a full buffer holds back the next step.
  word_buffer #(
    .W (WORD_W),
    .N (2)
  ) u_buffer (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (sample_valid),
    .in_ready  (buf_ready),
    .in_data   (next_word),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_data)
  );

  // =========================================================================
  // AXI4-Lite write path. Address and data are taken in either order and
  // held until both are present; the response follows.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (aw_held && w_held) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (aw_held && w_held) begin
      w_held <= 1'b0;
    end
  end

  // Register update with byte strobes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl      <= CTRL_RESET;
      delay_sel <= DELAY_RESET;
    end else if (aw_held && w_held) begin
      if (aw_addr == CTRL_OFF && w_strb[0]) begin
        ctrl <= w_data[3:0];
      end
      if (aw_addr == DELAY_OFF) begin
        if (w_strb[0]) begin
          delay_sel[7:0] <= w_data[7:0];
        end
        if (w_strb[1]) begin
          delay_sel[15:8] <= w_data[15:8];
        end
      end
    end
  end

  // Write response; status registers are read-only and answer with an error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (aw_held && w_held) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr == CTRL_OFF || aw_addr == DELAY_OFF) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // =========================================================================
  // AXI4-Lite read path, answered one cycle after the address is taken.
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case (s_axi_araddr)
        CTRL_OFF:   s_axi_rdata <= {28'h0000000, ctrl};
        DELAY_OFF:  s_axi_rdata <= {16'h0000, delay_sel};
        ACCUM_OFF:  s_axi_rdata <= {8'h00, accum};
        OUTPUT_OFF: s_axi_rdata <= {15'h0000, show_low, sum_output};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : product_sum_accumulate_output

/* File: verif/psao_asserts.sv */
/*
  Port checker for the product-sum accumulator.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module psao_asserts
  import mixer_pkg::*;
(
  // Clock, reset and streams
  input wire logic              aclk, aresetn, sample_valid, sample_ready,
  input wire logic              word_valid, word_ready,
  input wire logic [WORD_W-1:0] word_data, sum_output,
  // Register bus
  input wire logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [1:0]        s_axi_bresp, s_axi_rresp,
  input wire logic [31:0]       s_axi_rdata
);
  // ==========================================================================
  // Properties
  // All checks share one clock; reset masks them.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_full_refuse: assert property (!sample_ready |-> word_valid)
    else $error("refused with no word waiting");
  a_step_push: assert property (sample_valid && sample_ready && !word_valid |=> word_valid)
    else $error("step pushed no word");
  a_word_hold: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
    else $error("stalled word changed");
  a_sum_hold: assert property (!(sample_valid && sample_ready) |=> $stable(sum_output))
    else $error("sum bus moved without a step");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  a_read_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // Main scenarios reached.
  c_stall: cover property (!sample_ready);
  c_read_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_pop: cover property (word_valid && word_ready);
endmodule : psao_asserts

bind product_sum_accumulate_output psao_asserts i_psao_asserts (.*);

/* File: verif/word_sink.sv */
/*
  Far-side model: word consumer that can stall, and the external sum bus.
  Assumes one clock shared with the accumulator.
*/
`timescale 1ns/1ps
module word_sink (
  // Clock, reset, control
  input wire logic        aclk, aresetn, stall, oe_n,
  // Word stream and bus
  input wire logic        word_valid,
  input wire logic [15:0] word_data, sum_output,
  output logic            word_ready,
  output logic [15:0]     prev_word, last_word, bus
);
  // Ready is registered, so a stall lands one cycle late.
  always_ff @(posedge aclk) word_ready <= aresetn && !stall;
  // Keep the last two words popped for toggle checks.
  always_ff @(posedge aclk) begin
    if (word_valid && word_ready) begin
      prev_word <= last_word;
      last_word <= word_data;
    end
  end
  // A released bus shows the inverse so a floating line never matches.
  always_comb bus = oe_n ? ~sum_output : sum_output;
endmodule : word_sink

/* File: verif/product_sum_accumulate_output_test.sv */
/*
  Self-checking bench for the product-sum accumulator.
  Assumes the design answers over AXI4-Lite and a valid/ready sample stream.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module product_sum_accumulate_output_test;
  import mixer_pkg::*;
  logic aclk, aresetn, sample_valid, sample_ready, word_valid, word_ready, sum_output_oe_n;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, stall;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [15:0] word_data, sum_output, prev_word, last_word, bus;
  logic [23:0] p;
  sample_s sample, ls, z;
  int n_fail = 0;
  int num_checks = 0;
  product_sum_accumulate_output i_product_sum_accumulate_output (.*);
  word_sink i_word_sink (.aclk(aclk), .aresetn(aresetn), .stall(stall), .oe_n(sum_output_oe_n),
    .word_valid(word_valid), .word_data(word_data), .sum_output(sum_output),
    .word_ready(word_ready), .prev_word(prev_word), .last_word(last_word), .bus(bus));
  // ==========================================================================
  // Clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ==========================================================================
  // Tasks
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  // A wait that ran out ends the run at once.
  task automatic guard(input bit ok);
    if (!ok) begin
      n_fail++;
      $display("wrong value wait exp done got timeout");
      give_verdict();
    end
  endtask : guard
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] r);
    int i;
    bit done;
    i = 0;
    done = 0;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done && i < 200) begin
      @(posedge aclk);
      i++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        done = 1;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    guard(done);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
    int i;
    bit done;
    i = 0;
    done = 0;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done && i < 200) begin
      @(posedge aclk);
      i++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        done = 1;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    guard(done);
  endtask : axi_rd
  // Offer one sample until k steps have taken it.
  task automatic send(input sample_s s, input int k);
    int i;
    i = 0;
    @(posedge aclk);
    sample <= s;
    sample_valid <= 1'b1;
    while (k > 0 && i < 200) begin
      @(posedge aclk);
      i++;
      if (sample_ready) k--;
    end
    sample_valid <= 1'b0;
    guard(k == 0);
  endtask : send
  // Steady stream, then each output against the sum worked out here.
  task automatic run_case(input logic [3:0] ct, input logic [11:0] a, b, c, d,
      input logic [15:0] cs, input logic ce, n1, n2);
    logic signed [23:0] e, f;
    e = $signed(a) * $signed(b);
    if (n1) e = -e;
    f = $signed(c) * $signed(d);
    e = n2 ? e - f : e + f;
    if (!ce) e = e + {cs, 8'h00};
    if (ct[0]) e = e + ROUND_BIT;
    ls = '0;
    {ls.a, ls.b, ls.c, ls.d, ls.cascade_input} = {a, b, c, d, cs};
    {ls.cascade_input_enable_n, ls.product_one_negate, ls.product_two_negate} = {ce, n1, n2};
    axi_wr(CTRL_OFF, {28'h0, ct}, rs);
    send(ls, 8);
    repeat (6) @(posedge aclk);
    axi_rd(ACCUM_OFF, rd, rs);
    `CHK("accum", e, rd[23:0])
    `CHK("sum", e[23:8], sum_output)
    `CHK("bus", e[23:8], bus)
    `CHK("word", e[23:8], last_word)
    p = e;
  endtask : run_case
  // ==========================================================================
  // Main sequence
  initial begin
    {aresetn, sample_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready, stall} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    sample = '0;
    z = '0;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    `CHK("oe_n", 1'b1, sum_output_oe_n)
    `CHK("float", 16'hFFFF, bus)
    axi_rd(CTRL_OFF, rd, rs);
    `CHK("ctrl", 32'h0000000C, rd)
    axi_rd(8'h10, rd, rs);
    `CHK("unmapped", RESP_SLVERR, rs)
    axi_wr(ACCUM_OFF, 32'h1, rs);
    `CHK("ro write", RESP_SLVERR, rs)
    axi_wr(DELAY_OFF, 32'h0, rs);
    `CHK("delay", RESP_OKAY, rs)
    run_case(4'h4, 12'h003, 12'h005, 12'hFFE, 12'h007, 16'h0012, 1'b0, 1'b0, 1'b0);
    `CHK("oe_n", 1'b0, sum_output_oe_n)
    run_case(4'h5, 12'h800, 12'h7FF, 12'h009, 12'hFF9, 16'h8001, 1'b0, 1'b1, 1'b0);
    run_case(4'h6, 12'h003, 12'h005, 12'h002, 12'h002, 16'h0100, 1'b0, 1'b0, 1'b0);
    run_case(4'h7, 12'h064, 12'hF9C, 12'h001, 12'h001, 16'h7FFF, 1'b1, 1'b0, 1'b1);
    // One clearing sample, three summing ones, then zeros that add nothing.
    send(ls, 1);
    ls.accumulate_control = 1'b1;
    send(ls, 3);
    z.accumulate_control = 1'b1;
    z.cascade_input_enable_n = 1'b1;
    send(z, 8);
    p = p * 4 - 3 * ROUND_BIT;
    axi_rd(ACCUM_OFF, rd, rs);
    `CHK("acc sum", p, rd[23:0])
    // Toggle mode freezes the registers and alternates high and low words.
    axi_wr(CTRL_OFF, 32'h0, rs);
    repeat (8) @(posedge aclk);
    send(z, 2);
    repeat (6) @(posedge aclk);
    `CHK("high", p[23:8], prev_word)
    `CHK("low", p[15:0], last_word)
    axi_wr(CTRL_OFF, 32'h4, rs);
    // Stalled sink: two words fill the buffer, then input is refused.
    @(posedge aclk) stall <= 1'b1;
    repeat (8) @(posedge aclk);
    send(z, 2);
    #1;
    `CHK("refuse", 1'b0, sample_ready)
    @(posedge aclk) stall <= 1'b0;
    repeat (8) @(posedge aclk);
    `CHK("drained", 1'b0, word_valid)
    give_verdict();
  end
endmodule : product_sum_accumulate_output_test
